// ---- common/wtb_pkg.sv ----
package wtb_pkg;
  // ---------------------------------------------------------------
  // byte bus map of the timer
  // ---------------------------------------------------------------
  localparam int          ADDR_W  = 4;
  localparam logic [3:0]  A_CNT   = 4'h0;
  localparam logic [3:0]  A_CMPA  = 4'h2;
  localparam logic [3:0]  A_CMPB  = 4'h4;
  localparam logic [3:0]  A_CMPC  = 4'h6;
  localparam logic [3:0]  A_CAP   = 4'h8;
  localparam logic [3:0]  A_CTRLA = 4'ha;
  localparam logic [3:0]  A_CTRLB = 4'hb;
  localparam logic [3:0]  A_CTRLC = 4'hc;
  localparam logic [3:0]  A_FLAG  = 4'hd;
  localparam logic [3:0]  A_MASK  = 4'he;
  localparam int          NUM_CMP = 3;
  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int          NUM_FLAGS = 5;
  localparam int          F_OVF   = 0;
  localparam int          F_MATCH = 1;
  localparam int          F_CAP   = 4;
  localparam int          CA_TOP  = 0;
  localparam int          CA_PWM  = 3;
  localparam int          CB_CS   = 0;
  localparam int          CB_EDGE = 3;
  localparam int          CB_SRC  = 4;
  localparam int          CB_FILT = 5;
  localparam int          CC_FORCE = 0;
  localparam logic [2:0]  TOP_MAX = 3'h0;
  localparam logic [2:0]  TOP_8   = 3'h1;
  localparam logic [2:0]  TOP_9   = 3'h2;
  localparam logic [2:0]  TOP_10  = 3'h3;
  localparam logic [2:0]  TOP_CMPA = 3'h4;
  localparam logic [2:0]  TOP_CAP = 3'h5;
  localparam logic [2:0]  CS_STOP = 3'h0;
  localparam logic [2:0]  CS_DIV1 = 3'h1;
  localparam logic [2:0]  CS_DIV8 = 3'h2;
  localparam logic [2:0]  CS_DIV64 = 3'h3;
  localparam logic [2:0]  CS_DIV256 = 3'h4;
  localparam logic [2:0]  CS_DIV1024 = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;
  localparam logic [15:0] VAL_BOTTOM = 16'h0000;
  localparam logic [15:0] VAL_MAX  = 16'hffff;
  localparam logic [15:0] VAL_TOP8 = 16'h00ff;
  localparam logic [15:0] VAL_TOP9 = 16'h01ff;
  localparam logic [15:0] VAL_TOP10 = 16'h03ff;
  localparam int          PRE_W    = 10;
  localparam int          FILT_LEN = 4;
  // ---------------------------------------------------------------
  // controller registers on axi4-lite
  // ---------------------------------------------------------------
  localparam int          AXI_AW  = 8;
  localparam logic [7:0]  H_ADDR  = 8'h00;
  localparam logic [7:0]  H_WDATA = 8'h04;
  localparam logic [7:0]  H_CTRL  = 8'h08;
  localparam logic [7:0]  H_STAT  = 8'h0c;
  localparam logic [7:0]  H_RDATA = 8'h10;
  localparam int          HC_GO   = 0;
  localparam int          HC_READ = 1;
  localparam int          HC_WIDE = 2;
  localparam int          HC_PWR  = 3;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ---- common/wtb_if.sv ----
`timescale 1ns/1ps
interface wtb_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rdValid;
  logic       powerOff;
  logic       irq;
  modport dev  (input addr, wdata, wr, rd, powerOff, output rdata, rdValid, irq);
  modport host (output addr, wdata, wr, rd, powerOff, input rdata, rdValid, irq);
endinterface

// ---- verilog/wtb_device.sv ----
// What this block does
// - wide registers take two byte accesses
// - one shared high-byte staging register
// - low write loads staged high plus low
// - low counter or capture read copies high into staging
// - compare reads bypass staging register
// - write high first; read low first
// - wide accesses must not be interleaved
// - power-off bit keeps timer disabled
// - counter advances only on timer tick
// - double-buffered compares drive output pins
// - compare match sets channel match flag
// - three independent compare channels A B C
// - capture event copies counter to capture
// - capture input passes noise filter
// - top from mode: fixed, cmpA, capture
// - cmpA as pwm top: no A output
// - bottom at 0x0000, max at 0xffff
// - all requests flagged and individually masked
// - five interrupt sources per timer
// - control registers plain single-byte access
// - counter write beats count or clear
// - capture writable only in capture-top mode
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module wtb_device
  import wtb_pkg::*;
#(
  parameter int PRE_BITS  = PRE_W,
  parameter int FILT_CNT  = FILT_LEN
)(
  input  wire logic mclk,
  input  wire logic rst_n,
  wtb_if.dev        bus,
  input  wire logic capturePin,
  input  wire logic externalCountPin,
  input  wire logic comparatorOut,
  output logic      compareOutputA,
  output logic      compareOutputB,
  output logic      compareOutputC
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        wrEn, rdEn, isWide, isCmp, byteHigh;
  logic [2:0]  wideIdx;
  logic [15:0] wideSel;
  logic [7:0]  stageHigh_q;
  logic [15:0] counterValue_q, captureValue_q;
  logic [15:0] cmpBuf_q [NUM_CMP];
  logic [15:0] cmpAct_q [NUM_CMP];
  logic [7:0]  controlRegisterA_q, controlRegisterB_q;
  logic [NUM_FLAGS-1:0] timerFlag_q, timerMask_q;
  logic [7:0]  rdata_q;
  logic        rdValid_q, irq_q;

  assign wrEn     = bus.wr & ~bus.powerOff;
  assign rdEn     = bus.rd & ~bus.powerOff;
  assign byteHigh = bus.addr[0];
  assign wideIdx  = bus.addr[3:1];
  assign isWide   = bus.addr < A_CTRLA;
  assign isCmp    = (bus.addr[3:1] >= A_CMPA[3:1]) && (bus.addr[3:1] <= A_CMPC[3:1]);

  always_comb begin
    case (wideIdx)
      A_CNT[3:1]:  wideSel = counterValue_q;
      A_CMPA[3:1]: wideSel = cmpBuf_q[0];
      A_CMPB[3:1]: wideSel = cmpBuf_q[1];
      A_CMPC[3:1]: wideSel = cmpBuf_q[2];
      A_CAP[3:1]:  wideSel = captureValue_q;
      default:     wideSel = VAL_BOTTOM;
    endcase
  end

  // one staging byte serves every wide register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stageHigh_q <= 8'h00;
    end else if (wrEn && isWide && byteHigh) begin
      stageHigh_q <= bus.wdata;
    end else if (rdEn && isWide && !byteHigh && !isCmp) begin
      stageHigh_q <= wideSel[15:8];
    end
  end

  // ---------------------------------------------------------------
  // control, mask
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      controlRegisterA_q <= 8'h00;
      controlRegisterB_q <= 8'h00;
      timerMask_q        <= '0;
    end else if (wrEn) begin
      if (bus.addr == A_CTRLA) controlRegisterA_q <= bus.wdata;
      if (bus.addr == A_CTRLB) controlRegisterB_q <= bus.wdata;
      if (bus.addr == A_MASK)  timerMask_q <= bus.wdata[NUM_FLAGS-1:0];
    end
  end

  logic [2:0]  topSel, clkSel;
  logic        pwmMode, forceWr;
  assign topSel  = controlRegisterA_q[CA_TOP +: 3];
  assign pwmMode = controlRegisterA_q[CA_PWM];
  assign clkSel  = controlRegisterB_q[CB_CS +: 3];
  // force strobes act in the write cycle only and read back as zero
  assign forceWr = wrEn && (bus.addr == A_CTRLC);

  // ---------------------------------------------------------------
  // pin synchronisers: bit0 ext count, bit1 capture, bit2 comparator
  // ---------------------------------------------------------------
  logic [2:0] sync1_q, sync2_q, sync3_q, pinLevel_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q    <= 3'h0;
      sync2_q    <= 3'h0;
      sync3_q    <= 3'h0;
      pinLevel_q <= 3'h0;
    end else begin
      sync1_q    <= {comparatorOut, capturePin, externalCountPin};
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      pinLevel_q <= (sync3_q & ~(sync2_q ^ sync3_q)) | (pinLevel_q & (sync2_q ^ sync3_q));
    end
  end

  // ---------------------------------------------------------------
  // clock select and prescaler
  // ---------------------------------------------------------------
  logic [PRE_BITS-1:0] preCnt_q;
  logic                extPrev_q, tick;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_q  <= '0;
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= pinLevel_q[0];
      if (bus.powerOff || clkSel == CS_STOP) preCnt_q <= '0;
      else preCnt_q <= preCnt_q + 1'b1;
    end
  end

  always_comb begin
    case (clkSel)
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &preCnt_q[2:0];
      CS_DIV64:    tick = &preCnt_q[5:0];
      CS_DIV256:   tick = &preCnt_q[7:0];
      CS_DIV1024:  tick = &preCnt_q[9:0];
      CS_EXT_FALL: tick = extPrev_q & ~pinLevel_q[0];
      CS_EXT_RISE: tick = ~extPrev_q & pinLevel_q[0];
      default:     tick = 1'b0;
    endcase
    if (bus.powerOff) tick = 1'b0;
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [15:0] topVal;
  logic        atTop, atBottom, atMax;
  assign atBottom = counterValue_q == VAL_BOTTOM;
  assign atMax    = counterValue_q == VAL_MAX;
  always_comb begin
    case (topSel)
      TOP_8:    topVal = VAL_TOP8;
      TOP_9:    topVal = VAL_TOP9;
      TOP_10:   topVal = VAL_TOP10;
      TOP_CMPA: topVal = cmpAct_q[0];
      TOP_CAP:  topVal = captureValue_q;
      default:  topVal = VAL_MAX;
    endcase
  end
  assign atTop = (topSel == TOP_MAX) ? atMax : (counterValue_q == topVal);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      counterValue_q <= VAL_BOTTOM;
    end else if (wrEn && bus.addr == A_CNT) begin
      counterValue_q <= {stageHigh_q, bus.wdata};
    end else if (tick) begin
      if (atTop) counterValue_q <= VAL_BOTTOM;
      else counterValue_q <= counterValue_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  logic [NUM_CMP-1:0] matchEv, cmpOut_q;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CMP; ch++) begin : g_cmp
      localparam logic [2:0] IDX = 3'(A_CMPA[3:1] + ch);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cmpBuf_q[ch] <= VAL_BOTTOM;
          cmpAct_q[ch] <= VAL_BOTTOM;
          cmpOut_q[ch] <= 1'b0;
        end else begin
          if (wrEn && wideIdx == IDX && !byteHigh) begin
            cmpBuf_q[ch] <= {stageHigh_q, bus.wdata};
          end
          // pwm picks the new value up only at the period end, so no runt pulse
          if (!pwmMode || (tick && atTop)) cmpAct_q[ch] <= cmpBuf_q[ch];
          if (pwmMode) begin
            if (matchEv[ch]) cmpOut_q[ch] <= 1'b0;
            else if (tick && atBottom) cmpOut_q[ch] <= 1'b1;
          end else if (matchEv[ch] || (forceWr && bus.wdata[CC_FORCE + ch])) begin
            cmpOut_q[ch] <= ~cmpOut_q[ch];
          end
        end
      end
      assign matchEv[ch] = tick && (counterValue_q == cmpAct_q[ch]);
    end
  endgenerate

  assign compareOutputA = cmpOut_q[0] & ~(pwmMode && topSel == TOP_CMPA);
  assign compareOutputB = cmpOut_q[1];
  assign compareOutputC = cmpOut_q[2];

  // ---------------------------------------------------------------
  // input capture with noise filter
  // ---------------------------------------------------------------
  logic                capSrc, capEv, filtLevel_q, capPrev_q;
  logic [$clog2(FILT_CNT+1)-1:0] filtCnt_q;
  assign capSrc = controlRegisterB_q[CB_SRC] ? pinLevel_q[2] : pinLevel_q[1];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filtLevel_q <= 1'b0;
      filtCnt_q   <= '0;
      capPrev_q   <= 1'b0;
    end else begin
      capPrev_q <= filtLevel_q;
      if (!controlRegisterB_q[CB_FILT] || capSrc == filtLevel_q) begin
        filtLevel_q <= capSrc;
        filtCnt_q   <= '0;
      end else if (filtCnt_q == ($clog2(FILT_CNT+1))'(FILT_CNT - 1)) begin
        filtLevel_q <= capSrc;
        filtCnt_q   <= '0;
      end else begin
        filtCnt_q <= filtCnt_q + 1'b1;
      end
    end
  end
  assign capEv = (filtLevel_q != capPrev_q) && (filtLevel_q == controlRegisterB_q[CB_EDGE])
                 && !bus.powerOff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      captureValue_q <= VAL_BOTTOM;
    end else if (capEv) begin
      captureValue_q <= counterValue_q;
    end else if (wrEn && bus.addr == A_CAP && topSel == TOP_CAP) begin
      captureValue_q <= {stageHigh_q, bus.wdata};
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over write-one-to-clear
  // ---------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flagSet, flagClr;
  assign flagSet = {capEv, matchEv, tick && atTop};
  assign flagClr = (wrEn && bus.addr == A_FLAG) ? bus.wdata[NUM_FLAGS-1:0] : '0;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timerFlag_q <= '0;
      irq_q       <= 1'b0;
    end else begin
      timerFlag_q <= (timerFlag_q & ~flagClr) | flagSet;
      irq_q       <= |(timerFlag_q & timerMask_q);
    end
  end

  // ---------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q   <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
      if (rdEn) begin
        if (isWide && !byteHigh) rdata_q <= wideSel[7:0];
        else if (isWide && isCmp) rdata_q <= wideSel[15:8];
        else if (isWide) rdata_q <= stageHigh_q;
        else begin
          case (bus.addr)
            A_CTRLA: rdata_q <= controlRegisterA_q;
            A_CTRLB: rdata_q <= controlRegisterB_q;
            A_FLAG:  rdata_q <= 8'(timerFlag_q);
            A_MASK:  rdata_q <= 8'(timerMask_q);
            default: rdata_q <= 8'h00;
          endcase
        end
      end
    end
  end

  assign bus.rdata   = rdata_q;
  assign bus.rdValid = rdValid_q;
  assign bus.irq     = irq_q;
endmodule

// ---- verilog/wtb_host.sv ----
`timescale 1ns/1ps
module wtb_host
  import wtb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  wtb_if.host                    bus,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_B1 = 3'b001, S_B1W = 3'b011, S_B2 = 3'b010, S_B2W = 3'b110
  } wtbh_state_e;

  // ---------------------------------------------------------------
  // axi4-lite write side
  // ---------------------------------------------------------------
  logic              awHeld_q, wHeld_q, bvalid_q, doWrite;
  logic [AXI_AW-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q, opAddr_q;
  logic [15:0]       opData_q, rdRes_q;
  logic              opRead_q, opWide_q, powerOff_q;
  logic [1:0]        bresp_q;
  wtbh_state_e       state_q;
  logic              goReq;

  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready  = ~wHeld_q & ~bvalid_q;
  assign doWrite       = awHeld_q & wHeld_q & ~bvalid_q;
  assign goReq = doWrite && awAddr_q == H_CTRL && wStrb_q[0] && wData_q[HC_GO]
                 && state_q == S_IDLE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (awAddr_q == H_ADDR || awAddr_q == H_WDATA || awAddr_q == H_CTRL)
                    ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // staged operation fields may not change while a transfer runs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opAddr_q   <= 4'h0;
      opData_q   <= 16'h0000;
      opRead_q   <= 1'b0;
      opWide_q   <= 1'b0;
      powerOff_q <= 1'b1;
    end else if (doWrite) begin
      if (awAddr_q == H_ADDR && wStrb_q[0] && state_q == S_IDLE) opAddr_q <= wData_q[3:0];
      if (awAddr_q == H_WDATA && state_q == S_IDLE) begin
        if (wStrb_q[0]) opData_q[7:0]  <= wData_q[7:0];
        if (wStrb_q[1]) opData_q[15:8] <= wData_q[15:8];
      end
      if (awAddr_q == H_CTRL && wStrb_q[0]) begin
        powerOff_q <= wData_q[HC_PWR];
        if (goReq) begin
          opRead_q <= wData_q[HC_READ];
          opWide_q <= wData_q[HC_WIDE];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read side
  // ---------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  assign s_axi_arready = ~rvalid_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      case (s_axi_araddr)
        H_ADDR:  rdata_q <= {28'h0, opAddr_q};
        H_WDATA: rdata_q <= {16'h0, opData_q};
        H_CTRL:  rdata_q <= {28'h0, powerOff_q, opWide_q, opRead_q, 1'b0};
        H_STAT:  rdata_q <= {30'h0, bus.irq, state_q != S_IDLE};
        H_RDATA: rdata_q <= {16'h0, rdRes_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // byte sequencer: no other access can slip between the two bytes
  // ---------------------------------------------------------------
  logic [3:0] busAddr_q;
  logic [7:0] busWdata_q;
  logic       busWr_q, busRd_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= S_IDLE;
      busAddr_q  <= 4'h0;
      busWdata_q <= 8'h00;
      busWr_q    <= 1'b0;
      busRd_q    <= 1'b0;
      rdRes_q    <= 16'h0000;
    end else begin
      busWr_q <= 1'b0;
      busRd_q <= 1'b0;
      case (state_q)
        S_IDLE: if (goReq) begin
          state_q <= S_B1;
          busRd_q <= wData_q[HC_READ];
          busWr_q <= ~wData_q[HC_READ];
          // wide write: high byte first; wide read: low byte first
          busAddr_q  <= wData_q[HC_WIDE] ? {opAddr_q[3:1], ~wData_q[HC_READ]} : opAddr_q;
          busWdata_q <= wData_q[HC_WIDE] ? opData_q[15:8] : opData_q[7:0];
        end
        S_B1: state_q <= S_B1W;
        // a read refused while powered off must not hang the sequencer
        S_B1W: if (!opRead_q || bus.rdValid || powerOff_q) begin
          if (opRead_q) rdRes_q <= {8'h00, bus.rdata};
          if (opWide_q) begin
            state_q    <= S_B2;
            busRd_q    <= opRead_q;
            busWr_q    <= ~opRead_q;
            busAddr_q  <= {opAddr_q[3:1], opRead_q};
            busWdata_q <= opData_q[7:0];
          end else begin
            state_q <= S_IDLE;
          end
        end
        S_B2: state_q <= S_B2W;
        S_B2W: if (!opRead_q || bus.rdValid || powerOff_q) begin
          if (opRead_q) rdRes_q[15:8] <= bus.rdata;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign bus.addr     = busAddr_q;
  assign bus.wdata    = busWdata_q;
  assign bus.wr       = busWr_q;
  assign bus.rd       = busRd_q;
  assign bus.powerOff = powerOff_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
endmodule

// ---- tb/wtb_chk.sv ----
`timescale 1ns/1ps
module wtb_chk
  import wtb_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rdValid,
  input wire logic       powerOff
);
  // ---------------------------------------------------------------
  // shadow of staging, compare a and control a
  // ---------------------------------------------------------------
  logic [7:0]  stg_q;
  logic [7:0]  ctrlA_q;
  logic [15:0] cmpA_q;
  // counter or capture low reads also reload staging; bench avoids relying on that
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stg_q   <= 8'h00;
      ctrlA_q <= 8'h00;
      cmpA_q  <= 16'h0000;
    end else if (wr && !powerOff) begin
      if (addr[0] && addr < A_CTRLA) stg_q <= wdata;
      if (addr == A_CMPA) cmpA_q <= {stg_q, wdata};
      if (addr == A_CTRLA) ctrlA_q <= wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rdOn;
    rd && !powerOff;
  endsequence
  sequence rdCmpA;
    rdOn ##0 addr[3:1] == 3'h1;
  endsequence
  read_answer_a: assert property (rdOn |=> rdValid)
    else $error("byte read not answered next cycle");
  no_stray_a: assert property (rdValid |-> $past(rd && !powerOff))
    else $error("read answer without a read");
  power_gate_a: assert property (powerOff |=> !rdValid)
    else $error("answer while powered off");
  ctrl_readback_a: assert property (rdOn ##0 addr == A_CTRLA |=> rdata == $past(ctrlA_q))
    else $error("control a readback wrong");
  ctrlc_zero_a: assert property (rdOn ##0 addr == A_CTRLC |=> rdata == 8'h00)
    else $error("control c not read as zero");
  unmapped_zero_a: assert property (rdOn ##0 addr == 4'hf |=> rdata == 8'h00)
    else $error("unmapped byte not zero");
  cmp_bypass_a: assert property (rdCmpA |=> rdata == ($past(addr[0]) ?
    $past(cmpA_q[15:8]) : $past(cmpA_q[7:0]))) else $error("compare a byte wrong");
  rdata_hold_a: assert property (!rdValid |-> $stable(rdata))
    else $error("read data moved without a read");
endmodule

// ---- tb/wide_timer_byte_access_core_bench.sv ----
`timescale 1ns/1ps
module wide_timer_byte_access_core_bench;
  import wtb_pkg::*;
  typedef struct packed {logic [1:0] resp; logic [31:0] dat; logic [31:0] msk;} wtb_exp_s;
  logic        mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] r16;
  logic        cmpOutA, cmpOutB, cmpOutC;
  wtb_exp_s    expQ[$], ex;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  integer      seed = 32'hc751;
  wtb_if bus();
  always #5 mclk = ~mclk;
  wtb_host i_wtb_host (.mclk(mclk), .rst_n(rst_n), .bus(bus), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  wtb_device i_wtb_device (.mclk(mclk), .rst_n(rst_n), .bus(bus), .capturePin(1'b0),
    .externalCountPin(1'b0), .comparatorOut(1'b0), .compareOutputA(cmpOutA),
    .compareOutputB(cmpOutB), .compareOutputC(cmpOutC));
  wtb_chk i_wtb_chk (.mclk(mclk), .rst_n(rst_n), .addr(bus.addr), .wdata(bus.wdata),
    .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .rdValid(bus.rdValid), .powerOff(bus.powerOff));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if ((bvalid && bready) || (rvalid && rready)) begin
      ex = expQ.pop_front();
      check(bvalid ? {bresp, 32'h0} : {rresp, rdata & ex.msk}, {ex.resp, ex.dat});
    end
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // axi4-lite master and controller operations
  // ---------------------------------------------------------------
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back('{r, 32'h0, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task axr(input logic [7:0] a, input wtb_exp_s e);
    expQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // busy lasts four cycles after go, so eight leaves margin
  task op(input logic [3:0] a, input logic [15:0] d, input logic [3:0] c);
    axw(H_ADDR, {28'h0, a}, RESP_OKAY);
    axw(H_WDATA, {16'h0, d}, RESP_OKAY);
    axw(H_CTRL, {28'h0, c}, RESP_OKAY);
    repeat (8) @(posedge mclk);
  endtask
  task rdv(input logic [3:0] a, input logic [15:0] e, input logic w);
    op(a, 16'h0, w ? 4'h7 : 4'h3);
    axr(H_RDATA, '{RESP_OKAY, {16'h0, e}, w ? 32'hffff : 32'hff});
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    r16 = 16'($random(seed));
    op(A_CTRLA, 16'h0005, 4'h9);
    axw(H_CTRL, 32'h0, RESP_OKAY);
    rdv(A_CTRLA, 16'h0000, 1'b0);
    op(A_CTRLA, 16'h0003, 4'h1);
    rdv(A_CTRLA, 16'h0003, 1'b0);
    op(A_CMPA, r16, 4'h5);
    rdv(A_CMPA, r16, 1'b1);
    op(4'h3, 16'h005a, 4'h1);
    rdv(A_CMPA, r16, 1'b1);
    op(A_CMPA, 16'h00c3, 4'h1);
    rdv(A_CMPA, 16'h5ac3, 1'b1);
    op(4'h1, 16'h0077, 4'h1);
    op(A_CMPB, 16'h0011, 4'h1);
    rdv(A_CMPB, 16'h7711, 1'b1);
    op(A_CNT, 16'h1234, 4'h5);
    rdv(A_CNT, 16'h1234, 1'b1);
    op(A_CAP, 16'habcd, 4'h5);
    rdv(A_CAP, 16'h0000, 1'b1);
    op(A_CTRLA, {13'h0, TOP_CAP}, 4'h1);
    op(A_CAP, 16'habcd, 4'h5);
    rdv(A_CAP, 16'habcd, 1'b1);
    r16 = 16'($random(seed));
    op(A_MASK, {11'h0, r16[4:0]}, 4'h1);
    rdv(A_MASK, {11'h0, r16[4:0]}, 1'b0);
    // run from just below compare b, stop well before any other match or top
    op(A_CNT, 16'h7708, 4'h5);
    op(A_CTRLB, {13'h0, CS_DIV1}, 4'h1);
    op(A_CTRLB, 16'h0000, 4'h1);
    rdv(A_FLAG, 16'h0004, 1'b0);
    axr(H_STAT, '{RESP_OKAY, {30'h0, r16[2], 1'b0}, 32'h3});
    check({31'h0, cmpOutA, cmpOutB, cmpOutC}, 34'h2);
    rdv(A_CTRLC, 16'h0000, 1'b0);
    rdv(4'hf, 16'h0000, 1'b0);
    axw(8'h20, 32'h1, RESP_SLVERR);
    axr(8'h20, '{RESP_SLVERR, 32'h0, 32'h0});
    tally_and_finish();
  end
endmodule
